/* common/oprst_pkg.sv */
// Package of constants and carrier types for the output power-on reset timer.
// Assumes a single converter oscillator clock of 10 MHz drives all users.
package oprst_pkg;

  // Converter oscillator period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Power-good hold count before reset release, in oscillator cycles.
  localparam int unsigned RELEASE_CYCLES = 65536;

  // Undervoltage filter time, in nanoseconds (about 30 us).
  localparam int unsigned UV_FILTER_NS = 30000;

  // Undervoltage filter length: a least time, so round up.
  localparam int unsigned UV_FILTER_CYCLES =
    (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset value of the open-drain enable: low means pulling the pin down.
  localparam logic RST_OE_N_RESET = 1'b0;

  // Synchronised comparator inputs.
  typedef struct packed {
    logic pgood;
    logic uv;
    logic run;
  } oprst_mon_t;

  // States of the reset timer.
  typedef enum logic [1:0] {
    OPRST_HOLD,
    OPRST_COUNT,
    OPRST_RELEASED
  } oprst_state_t;

endpackage : oprst_pkg

/* verilog/oprst_sync.sv */
// Three-stage input synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk; output changes once stages agree.
`timescale 1ns/1ns
`default_nettype none
module oprst_sync
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic pin,
  output logic level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // The first stage feeds only the second, to keep metastability contained.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end
    else if (ce)
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      level <= RESET_VAL;
    end
    else if (ce && (s2_reg == s3_reg))
    begin
      level <= s3_reg;
    end
  end

endmodule : oprst_sync
`default_nettype wire

/* verilog/oprst_timer.sv */
// Output power-on reset timer: drives the open-drain reset pin of the system.
// Assumes comparator and run inputs are asynchronous pins; one 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module oprst_timer
#(
  parameter int unsigned RELEASE_CYCLES = oprst_pkg::RELEASE_CYCLES,
  parameter int unsigned UV_CYCLES = oprst_pkg::UV_FILTER_CYCLES
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic pgood_pin,
  input wire logic uv_pin,
  input wire logic run_pin,
  output logic rst_pin_o,
  output logic rst_pin_oe_n,
  output logic counting
);

  localparam int CW = $clog2(RELEASE_CYCLES + 1);
  localparam int UW = $clog2(UV_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(RELEASE_CYCLES - 1);
  localparam logic [UW-1:0] UV_LAST = UW'(UV_CYCLES - 1);

  oprst_pkg::oprst_mon_t mon;
  oprst_pkg::oprst_state_t state_reg;
  logic [CW-1:0] cnt_reg;
  logic [UW-1:0] uv_cnt_reg;
  logic uv_trip;
  logic shutdown;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // The run input is the 1.3V run comparison; low means shutdown.
  oprst_sync #(.RESET_VAL(1'b0)) u_sync_run
  (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .pin(run_pin),
    .level(mon.run)
  );

  oprst_sync #(.RESET_VAL(1'b0)) u_sync_pgood
  (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .pin(pgood_pin),
    .level(mon.pgood)
  );

  oprst_sync #(.RESET_VAL(1'b0)) u_sync_uv
  (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .pin(uv_pin),
    .level(mon.uv)
  );

  assign shutdown = !mon.run;

  ////////////////////////////////////////////////////////////////////////////
  // Undervoltage filter.

  // Short dips are ignored so that load steps do not reset the system.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      uv_cnt_reg <= '0;
    end
    else if (ce)
    begin
      if (!mon.uv || shutdown)
      begin
        uv_cnt_reg <= '0;
      end
      else if (uv_cnt_reg != UV_LAST)
      begin
        uv_cnt_reg <= uv_cnt_reg + 1'b1;
      end
    end
  end

  assign uv_trip = mon.uv && !shutdown && (uv_cnt_reg == UV_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Reset timer state and delay counter.

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= oprst_pkg::OPRST_HOLD;
    end
    else if (ce)
    begin
      if (shutdown)
      begin
        state_reg <= oprst_pkg::OPRST_HOLD;
      end
      else
      begin
        unique case (state_reg)
          oprst_pkg::OPRST_HOLD:
          begin
            if (mon.pgood)
            begin
              state_reg <= oprst_pkg::OPRST_COUNT;
            end
          end
          oprst_pkg::OPRST_COUNT:
          begin
            if (!mon.pgood)
            begin
              state_reg <= oprst_pkg::OPRST_HOLD;
            end
            else if (cnt_reg == CNT_LAST)
            begin
              state_reg <= oprst_pkg::OPRST_RELEASED;
            end
          end
          oprst_pkg::OPRST_RELEASED:
          begin
            if (uv_trip)
            begin
              state_reg <= oprst_pkg::OPRST_HOLD;
            end
          end
        endcase
      end
    end
  end

  // Clearing on any loss means every release needs a full unbroken count.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_reg <= '0;
    end
    else if (ce)
    begin
      if (shutdown || !mon.pgood || state_reg != oprst_pkg::OPRST_COUNT)
      begin
        cnt_reg <= '0;
      end
      else
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain reset output.

  // The pin data is always low; only the enable decides pull-down or release.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_n <= oprst_pkg::RST_OE_N_RESET;
      counting <= 1'b0;
    end
    else if (ce)
    begin
      rst_pin_o <= 1'b0;
      rst_pin_oe_n <= (state_reg == oprst_pkg::OPRST_RELEASED)
        && !shutdown && !uv_trip;
      counting <= (state_reg == oprst_pkg::OPRST_COUNT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_shutdown_holds: assert property (@(posedge clk) disable iff (!resetn)
    ce && shutdown |=> !rst_pin_oe_n)
    else $error("Reset released during shutdown.");

  // The counter overshoots by one on the release edge, so look one tick back.
  a_release_count: assert property (@(posedge clk) disable iff (!resetn)
    $changed(state_reg) && state_reg == oprst_pkg::OPRST_RELEASED
    |-> $past(cnt_reg) == CNT_LAST)
    else $error("Reset released without a full count.");

  a_count_clear: assert property (@(posedge clk) disable iff (!resetn)
    ce && (shutdown || !mon.pgood) |=> cnt_reg == '0)
    else $error("Delay counter not cleared.");

  a_count_start: assert property (@(posedge clk) disable iff (!resetn)
    ce && !shutdown && mon.pgood && state_reg == oprst_pkg::OPRST_HOLD
    |=> state_reg == oprst_pkg::OPRST_COUNT)
    else $error("Count did not start on power-good.");

  a_uv_asserts: assert property (@(posedge clk) disable iff (!resetn)
    ce && uv_trip |=> !rst_pin_oe_n)
    else $error("Filtered undervoltage did not assert reset.");

  a_pin_low: assert property (@(posedge clk) disable iff (!resetn)
    !rst_pin_o)
    else $error("Open-drain data not low.");

  a_hold_low: assert property (@(posedge clk) disable iff (!resetn)
    ce && state_reg == oprst_pkg::OPRST_HOLD |=> !rst_pin_oe_n)
    else $error("Reset released while holding.");

  a_run_state: assert property (@(posedge clk) disable iff (!resetn)
    ce && !mon.run |=> state_reg == oprst_pkg::OPRST_HOLD)
    else $error("Shutdown did not return to hold.");

  c_release: cover property (@(posedge clk) $rose(rst_pin_oe_n));
  c_uv_trip: cover property (@(posedge clk) uv_trip);
  c_count_abort: cover property (@(posedge clk)
    state_reg == oprst_pkg::OPRST_COUNT && !mon.pgood);

endmodule : oprst_timer
`default_nettype wire

/* dv/oprst_sysreset_model.sv */
// System logic that receives the open-drain reset line.
// Assumes an external pull-up; the timer only ever pulls the line low.
`timescale 1ns/1ns
`default_nettype none
module oprst_sysreset_model
(
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n,
  output logic sys_reset_n
);
  // The pull-up wins whenever the pull-down is off, never a stale value.
  assign sys_reset_n = (rst_pin_oe_n == 1'b0) ? rst_pin_o : 1'b1;
endmodule : oprst_sysreset_model
`default_nettype wire

/* dv/oprst_timer_bench.sv */
// Self-checking bench of the power-on reset timer with a short count.
// Assumes the timer design and the system reset model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module oprst_timer_bench;
  localparam int unsigned REL = 16;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic pgood_pin = 1'b0;
  logic uv_pin = 1'b0;
  logic run_pin = 1'b0;
  logic rst_pin_o;
  logic rst_pin_oe_n;
  logic counting;
  logic sys_reset_n;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int k;
  //////////////////////////////////////////////////////////////////////////
  initial forever #50 clk = ~clk;
  oprst_timer #(.RELEASE_CYCLES(REL), .UV_CYCLES(4)) i_dut
  (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .pgood_pin(pgood_pin),
    .uv_pin(uv_pin),
    .run_pin(run_pin),
    .rst_pin_o(rst_pin_o),
    .rst_pin_oe_n(rst_pin_oe_n),
    .counting(counting)
  );
  oprst_sysreset_model i_sys
  (
    .rst_pin_o(rst_pin_o),
    .rst_pin_oe_n(rst_pin_oe_n),
    .sys_reset_n(sys_reset_n)
  );
  //////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step
  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Waits for a level on the enable, giving up after a bounded count.
  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while (rst_pin_oe_n !== lvl && n < 200)
    begin
      step(1);
      n++;
    end
  endtask : wait_oe
  task automatic start_count;
    k = 0;
    while (counting !== 1'b1 && k < 20)
    begin
      step(1);
      k++;
    end
    chk("counting", 1'b1, counting);
    wait_oe(1'b1, k);
    chk("full count", 1'b1, k >= REL && k <= REL + 4);
    chk("line high", 1'b1, sys_reset_n);
  endtask : start_count
  //////////////////////////////////////////////////////////////////////////
  task automatic t_power_up;
    chk("oe_n at reset", 1'b0, rst_pin_oe_n);
    chk("data", 1'b0, rst_pin_o);
    pgood_pin = 1'b1;
    step(30);
    chk("shutdown oe_n", 1'b0, rst_pin_oe_n);
    chk("shutdown count", 1'b0, counting);
    run_pin = 1'b1;
    start_count();
  endtask : t_power_up
  task automatic t_undervolt;
    uv_pin = 1'b1;
    step(2);
    uv_pin = 1'b0;
    step(10);
    chk("uv glitch", 1'b1, rst_pin_oe_n);
    uv_pin = 1'b1;
    wait_oe(1'b0, k);
    chk("uv filter", 1'b1, k >= 4 && k <= 14);
    chk("line low", 1'b0, sys_reset_n);
    uv_pin = 1'b0;
  endtask : t_undervolt
  task automatic t_restart;
    step(10);
    pgood_pin = 1'b0;
    step(8);
    chk("count cleared", 1'b0, counting);
    chk("held", 1'b0, rst_pin_oe_n);
    pgood_pin = 1'b1;
    start_count();
  endtask : t_restart
  task automatic t_shutdown;
    run_pin = 1'b0;
    wait_oe(1'b0, k);
    chk("shutdown fast", 1'b1, k <= 10);
    step(20);
    chk("shutdown hold", 1'b0, rst_pin_oe_n);
    run_pin = 1'b1;
    step(3);
    chk("leave shutdown", 1'b0, rst_pin_oe_n);
    start_count();
  endtask : t_shutdown
  // A low enable freezes the synchronisers too, so shutdown waits for it.
  task automatic t_freeze;
    ce = 1'b0;
    run_pin = 1'b0;
    step(20);
    chk("frozen oe_n", 1'b1, rst_pin_oe_n);
    ce = 1'b1;
    wait_oe(1'b0, k);
    chk("resume shutdown", 1'b1, k <= 10);
    run_pin = 1'b1;
    start_count();
  endtask : t_freeze
  task automatic t_midreset;
    resetn = 1'b0;
    step(2);
    chk("reset oe_n", 1'b0, rst_pin_oe_n);
    chk("reset count", 1'b0, counting);
    resetn = 1'b1;
    start_count();
  endtask : t_midreset
  //////////////////////////////////////////////////////////////////////////
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      complete_run();
    end
  end
  initial
  begin
    step(20);
    resetn = 1'b1;
    t_power_up();
    t_undervolt();
    t_restart();
    t_shutdown();
    t_freeze();
    t_midreset();
    complete_run();
  end
endmodule : oprst_timer_bench
`default_nettype wire
